/* bench/dsp_access_properties.sv */
// Purpose: port-level checks on dsp_cpu_access
// Assumes: link pins are sampled on clk_i, never used as a clock
// Notes:   hidden bus control state is judged only while the link stays idle
`timescale 1ns/1ps
module dsp_access_properties (
   input wire        clk_i,
   input wire        nrst_i,
   input wire        link_clk_i,
   input wire        link_data_i,
   input wire        acc_req_o,
   input wire [7:0]  acc_code_o,
   input wire [23:0] acc_wdata_o,
   input wire        acc_long_sp_o,
   input wire        full_address_mode_o,
   input wire        acc_done_i,
   input wire        bus_acknowledge_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // idle link for six cycles: no register write can be in flight
   sequence quiet_s; (link_clk_i && link_data_i) [*6]; endsequence
   sequence pending_s; acc_req_o [*2]; endsequence
   // request held steady until the cpu answers
   req_hold_a: assert property (acc_req_o && !acc_done_i |=> acc_req_o && $stable(acc_code_o)
      && $stable(acc_wdata_o)) else $error("request dropped or changed early");
   req_done_a: assert property (acc_req_o && acc_done_i |=> !acc_req_o)
      else $error("request outlived done");
   // command follows the eighth bit rise within a few cycles
   cmd_prompt_a: assert property ($rose(acc_req_o) |-> $past(link_clk_i, 2)
      && !$past(link_clk_i, 6)) else $error("request not tied to a command byte");
   sp_select_a: assert property (acc_long_sp_o == full_address_mode_o)
      else $error("stack pointer choice differs from mode");
   no_req_code_a: assert property ($rose(acc_req_o) |->
      !(acc_code_o inside {8'h08, 8'h09, 8'h88, 8'h89, 8'h8a})) else $error("bad request code");
   mode_steady_a: assert property (quiet_s |-> $stable(full_address_mode_o))
      else $error("mode changed without command");
   mem_narrow_a: assert property (acc_req_o && acc_code_o == 8'h8b |->
      acc_wdata_o[23:8] == 16'h0) else $error("memory write not narrowed");
   // access still pending at the judged cycle; quiet link keeps force unchanged
   ack_blocked_a: assert property (quiet_s ##0 pending_s ##0 !$past(bus_acknowledge_pin_o)
      |-> !bus_acknowledge_pin_o) else $error("grant during pending access");
endmodule // dsp_access_properties

/* bench/dsp_cpu_access_tb.sv */
// Purpose: self-checking bench for dsp_cpu_access
// Assumes: bench stands in for the cpu; the data wire has a pull-up
// Notes:   cpu answers each request with {code, ~code, 5a} after lat cycles
`timescale 1ns/1ps
module dsp_cpu_access_tb;
   logic        clk_i = 1'b0, nrst_i = 1'b0, acc_done_i = 1'b0, bus_request_pin_i = 1'b0;
   logic [23:0] acc_rdata_i = 24'h0, got_w, v;
   logic [7:0]  got_c, c;
   logic        m_clk, m_d, m_oe;
   wire         link_data_o, link_data_oe_o, acc_req_o, acc_long_sp_o, full_address_mode_o;
   wire         bus_acknowledge_pin_o;
   wire [7:0]   acc_code_o;
   wire [23:0]  acc_wdata_o;
   wire         lw = link_data_oe_o ? link_data_o : (m_oe ? m_d : 1'b1);
   int          mismatches = 0, n_tests = 0, nreq = 0, lat = 0, i, k;
   always #50 clk_i = ~clk_i;
   dsp_cpu_access dsp_cpu_access_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link_clk_i(m_clk),
      .link_data_i(lw), .link_data_o(link_data_o), .link_data_oe_o(link_data_oe_o),
      .acc_req_o(acc_req_o), .acc_code_o(acc_code_o), .acc_wdata_o(acc_wdata_o),
      .acc_long_sp_o(acc_long_sp_o), .full_address_mode_o(full_address_mode_o),
      .acc_done_i(acc_done_i), .acc_rdata_i(acc_rdata_i),
      .bus_request_pin_i(bus_request_pin_i), .bus_acknowledge_pin_o(bus_acknowledge_pin_o));
   dsp_link_master dsp_link_master_inst (.link_clk_o(m_clk), .data_o(m_d), .oe_o(m_oe),
      .wire_i(lw));
   // cpu stand-in; read data is scrambled once done has passed
   initial forever begin
      @(posedge clk_i);
      #1;
      if (acc_req_o === 1'b1) begin
         nreq++;
         got_c = acc_code_o;
         got_w = acc_wdata_o;
         repeat (lat) @(posedge clk_i);
         #1 acc_done_i = 1'b1;
         acc_rdata_i = {acc_code_o, ~acc_code_o, 8'h5a};
         @(posedge clk_i) #1 acc_done_i = 1'b0;
         acc_rdata_i = ~acc_rdata_i;
      end
   end
   task check(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [6:0] a, input int n, input logic [31:0] d);
      dsp_link_master_inst.frame(a, 1'b0, n, d, v);
   endtask
   task rd3;
      dsp_link_master_inst.frame(7'h10, 1'b1, 3, 32'h0, v);
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #5000000 mismatches++;
      conclude;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      // write codes: data bytes and command in one frame
      for (i = 0; i < 8; i++) begin
         c = 8'h80 + i[7:0];
         wr(7'h13, 4, {c ^ 8'h3c, c ^ 8'hc3, c ^ 8'h55, c});
         check("wr code", {16'h0, c}, {16'h0, got_c});
         check("wr data", {c ^ 8'h3c, c ^ 8'hc3, c ^ 8'h55}, got_w);
      end
      $display("write commands ended");
      // read codes land in the holding bytes
      for (i = 0; i < 8; i++) begin
         c = i[7:0];
         wr(7'h16, 1, {c, 24'h0});
         rd3;
         check("rd bytes", {c, ~c, 8'h5a}, v);
      end
      wr(7'h16, 1, 32'h0b00_0000);
      rd3;
      check("mem rd", 24'h00005a, v);
      wr(7'h13, 4, 32'habcd_ef8b);
      check("mem wr", 24'h0000ef, got_w);
      $display("read commands ended");
      // mode commands and reserved codes raise no request
      k = nreq;
      wr(7'h16, 1, 32'h0800_0000);
      check("mode set", 24'h1, {23'h0, full_address_mode_o});
      wr(7'h16, 1, 32'h0600_0000);
      check("long sp", 24'h1, {23'h0, acc_long_sp_o});
      wr(7'h16, 1, 32'h0900_0000);
      check("mode clr", 24'h0, {23'h0, full_address_mode_o});
      check("short sp", 24'h0, {23'h0, acc_long_sp_o});
      for (i = 0; i < 3; i++) wr(7'h16, 1, {8'h88 + i[7:0], 24'h0});
      check("req count", k + 1, nreq);
      // exchange raises a request and leaves the read bytes of the last read
      wr(7'h16, 1, 32'h0a00_0000);
      rd3;
      check("exchange", 24'h00000a, {16'h0, got_c});
      check("xchg keeps", {8'h06, 8'hf9, 8'h5a}, v);
      $display("mode tests ended");
      // bus grant control
      @(posedge clk_i) #1 bus_request_pin_i = 1'b1;
      repeat (6) @(posedge clk_i);
      check("ack off", 24'h0, {23'h0, bus_acknowledge_pin_o});
      wr(7'h17, 1, 32'h8000_0000);
      check("ack en", 24'h1, {23'h0, bus_acknowledge_pin_o});
      lat = 40;
      wr(7'h16, 1, 32'h0700_0000);
      check("ack pend", 24'h0, {23'h0, bus_acknowledge_pin_o});
      repeat (40) @(posedge clk_i);
      check("ack after", 24'h1, {23'h0, bus_acknowledge_pin_o});
      lat = 0;
      #1 bus_request_pin_i = 1'b0;
      wr(7'h17, 1, 32'h4000_0000);
      check("ack force", 24'h1, {23'h0, bus_acknowledge_pin_o});
      wr(7'h17, 1, 32'h0);
      check("ack free", 24'h0, {23'h0, bus_acknowledge_pin_o});
      $display("bus tests ended");
      conclude;
   end
endmodule // dsp_cpu_access_tb
bind dsp_cpu_access dsp_access_properties dsp_access_properties_inst (.clk_i(clk_i),
   .nrst_i(nrst_i), .link_clk_i(link_clk_i), .link_data_i(link_data_i),
   .acc_req_o(acc_req_o), .acc_code_o(acc_code_o), .acc_wdata_o(acc_wdata_o),
   .acc_long_sp_o(acc_long_sp_o), .full_address_mode_o(full_address_mode_o),
   .acc_done_i(acc_done_i), .bus_acknowledge_pin_o(bus_acknowledge_pin_o));

/* bench/dsp_link_master.sv */
// Purpose: behavioural debug master on the serial link
// Assumes: link clock idles high and stands still between frames
// Notes:   samples late in the high phase, since the slave answers 2-3 clk after a fall
`timescale 1ns/1ps
module dsp_link_master (
   output logic      link_clk_o,
   output logic      data_o,
   output logic      oe_o,
   input  wire logic wire_i
);
   initial begin
      link_clk_o = 1'b1;
      data_o = 1'b1;
      oe_o = 1'b1;
   end
   // one bit: data changes only while the clock is low
   task bitx(input logic drv, input logic v, output logic s);
      link_clk_o = 1'b0;
      oe_o = drv;
      data_o = drv ? v : ~data_o;
      #400 link_clk_o = 1'b1;
      #350 s = wire_i;
      #50;
   endtask
   // frame of n bytes msb first; a read shifts the slave bytes into rb
   task frame(input logic [6:0] a, input logic rw, input int n, input logic [31:0] wb,
              output logic [23:0] rb);
      logic s;
      int i, j;
      #37 data_o = 1'b0;
      #400;
      for (i = 7; i >= 0; i--) bitx(1'b1, i ? a[i-1] : rw, s);
      bitx(1'b0, 1'b1, s);
      for (j = 0; j < n; j++) begin
         for (i = 0; i < 8; i++) begin
            bitx(!rw, wb[31], s);
            wb = wb << 1;
            rb = {rb[22:0], s};
         end
         bitx(1'b0, 1'b1, s);
      end
      // end by start then stop with the clock held high; another clock fall
      // would make a reading slave load and drive its next byte
      oe_o = 1'b1;
      data_o = 1'b0;
      #400 data_o = 1'b1; // stop: data rises while clock high
      #400;
   endtask
endmodule // dsp_link_master

/* design/dsp_consts.vh */
// Purpose: constants shared by the debug serial port access logic
// Assumes: included by bare name from the design files
// Notes:   link offsets are seven-bit register addresses on the serial link
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// write-only address space
`define DSP_ADDR_WR_UPPER   7'h13
`define DSP_ADDR_WR_HIGH    7'h14
`define DSP_ADDR_WR_LOW     7'h15
`define DSP_ADDR_CMD        7'h16
`define DSP_ADDR_BUS_CTL    7'h17

// read-only address space, holding bytes of the last read command
`define DSP_ADDR_RD_UPPER   7'h10
`define DSP_ADDR_RD_HIGH    7'h11
`define DSP_ADDR_RD_LOW     7'h12

// bus grant control layout and reset
`define DSP_BUS_EN_BIT      7
`define DSP_BUS_FORCE_BIT   6
`define DSP_BUS_CTL_RESET   8'h00

// command codes
`define DSP_CMD_RD_AF       8'h00
`define DSP_CMD_RD_PC       8'h07
`define DSP_CMD_SET_FULL    8'h08
`define DSP_CMD_CLR_FULL    8'h09
`define DSP_CMD_EXCHANGE    8'h0a
`define DSP_CMD_RD_MEM      8'h0b
`define DSP_CMD_WR_AF       8'h80
`define DSP_CMD_WR_PC       8'h87
`define DSP_CMD_WR_MEM      8'h8b

// link framing
`define DSP_BITS_PER_BYTE   4'd8
`define DSP_SEP_SLOT        4'd8

`endif

/* design/dsp_cpu_access.v */
// Purpose: debug cpu access commands and bus grant control behind the debug serial port
// Assumes: cpu answers each access request with a one-cycle done pulse on clk_i
// Notes:   link is sampled, not used as a clock; bus pins are active high
//
// Behaviour
// - command byte write starts cpu operation immediately; the code drops one written while an access is pending
// - read commands fill upper, high, low read bytes
// - write commands take value from write bytes
// - narrower writes use least significant write bytes
// - code 00 reads, 80 writes memory base, flags, accumulator
// - stack pointer access selects long or short pointer
// - code 07 reads, 87 writes program counter
// - code 0a swaps main and alternate register sets
// - code 0b reads memory at pc, increments pc
// - code 8b writes memory at pc, increments pc
// - enable clear ignores bus requests entirely
// - enable set grants after current operation finishes
// - force bit one asserts bus acknowledge
// - force bit zero releases bus acknowledge unless enable is set and a request is granted
`timescale 1ns/1ps
`include "dsp_consts.vh"

module dsp_cpu_access (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        link_clk_i,
   input  wire        link_data_i,
   output wire        link_data_o,
   output wire        link_data_oe_o,
   output wire        acc_req_o,
   output wire [7:0]  acc_code_o,
   output wire [23:0] acc_wdata_o,
   output wire        acc_long_sp_o,
   output wire        full_address_mode_o,
   input  wire        acc_done_i,
   input  wire [23:0] acc_rdata_i,
   input  wire        bus_request_pin_i,
   output wire        bus_acknowledge_pin_o
);

   wire        wr_stb;
   wire [6:0]  wr_addr;
   wire [7:0]  wr_data;
   wire [6:0]  rd_addr;
   reg  [7:0]  rd_byte;

   reg  [7:0]  write_data_upper_r;
   reg  [7:0]  write_data_high_r;
   reg  [7:0]  write_data_low_r;
   reg  [23:0] read_data_r;
   reg         bus_grant_enable_r;
   reg         bus_grant_force_r;
   reg         full_address_mode_r;
   reg         acc_req_r;
   reg  [7:0]  acc_code_r;
   reg  [23:0] acc_wdata_r;
   reg         breq_s1_r;
   reg         breq_s2_r;
   reg         bus_ack_r;
   reg         bus_ack_nxt;

   // reset image of the bus control byte, kept whole so single bits can be picked
   localparam [7:0] BUS_CTL_RST = `DSP_BUS_CTL_RESET;

   // command classes decoded from the byte being written
   reg         cmd_is_read;
   reg         cmd_is_write;
   reg         cmd_is_xchg;
   reg  [23:0] cmd_wdata;

   wire cmd_wr = wr_stb && (wr_addr == `DSP_ADDR_CMD);
   wire bus_wr = wr_stb && (wr_addr == `DSP_ADDR_BUS_CTL);
   wire [23:0] write_word = {write_data_upper_r, write_data_high_r, write_data_low_r};

   // serial slave of the link
   dsp_link u_link (
      .clk_i          (clk_i),
      .nrst_i         (nrst_i),
      .link_clk_i     (link_clk_i),
      .link_data_i    (link_data_i),
      .link_data_o    (link_data_o),
      .link_data_oe_o (link_data_oe_o),
      .wr_stb_o       (wr_stb),
      .wr_addr_o      (wr_addr),
      .wr_data_o      (wr_data),
      .rd_addr_o      (rd_addr),
      .rd_data_i      (rd_byte)
   );

   // read space mux; unmapped addresses read as zero
   always @* begin
      case (rd_addr)
         `DSP_ADDR_RD_UPPER: rd_byte = read_data_r[23:16];
         `DSP_ADDR_RD_HIGH:  rd_byte = read_data_r[15:8];
         `DSP_ADDR_RD_LOW:   rd_byte = read_data_r[7:0];
         default:            rd_byte = 8'h00;
      endcase
   end

   // write-data holding bytes, loaded ahead of a write command
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         write_data_upper_r <= 8'h00;
         write_data_high_r  <= 8'h00;
         write_data_low_r   <= 8'h00;
      end else if (wr_stb) begin
         if (wr_addr == `DSP_ADDR_WR_UPPER) begin
            write_data_upper_r <= wr_data;
         end
         if (wr_addr == `DSP_ADDR_WR_HIGH) begin
            write_data_high_r <= wr_data;
         end
         if (wr_addr == `DSP_ADDR_WR_LOW) begin
            write_data_low_r <= wr_data;
         end
      end
   end

   // classify the command byte; gaps in the table fall to no action
   always @* begin
      cmd_is_read  = 1'b0;
      cmd_is_write = 1'b0;
      cmd_is_xchg  = 1'b0;
      cmd_wdata    = write_word;
      if ((wr_data >= `DSP_CMD_RD_AF && wr_data <= `DSP_CMD_RD_PC) ||
          wr_data == `DSP_CMD_RD_MEM) begin
         cmd_is_read = 1'b1;
      end
      if (wr_data >= `DSP_CMD_WR_AF && wr_data <= `DSP_CMD_WR_PC) begin
         cmd_is_write = 1'b1;
      end
      if (wr_data == `DSP_CMD_WR_MEM) begin
         cmd_is_write = 1'b1;
         cmd_wdata    = {16'h0000, write_data_low_r};
      end
      if (wr_data == `DSP_CMD_EXCHANGE) begin
         cmd_is_xchg = 1'b1;
      end
   end

   // cpu access sequencer: a command byte raises the request on the next edge,
   // the cpu's done pulse ends it; commands arriving while busy are dropped
   // rather than queued, which keeps the cpu port a single outstanding access
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_req_r           <= 1'b0;
         acc_code_r          <= 8'h00;
         acc_wdata_r         <= 24'h000000;
         read_data_r         <= 24'h000000;
         full_address_mode_r <= 1'b0;
      end else begin
         if (acc_req_r && acc_done_i) begin
            acc_req_r <= 1'b0;
            if (acc_code_r == `DSP_CMD_RD_MEM) begin
               read_data_r <= {16'h0000, acc_rdata_i[7:0]};
            end else if (!acc_code_r[7] && acc_code_r != `DSP_CMD_EXCHANGE) begin
               read_data_r <= acc_rdata_i;
            end
         end
         if (cmd_wr && !acc_req_r) begin
            if (cmd_is_read || cmd_is_write || cmd_is_xchg) begin
               acc_req_r   <= 1'b1;
               acc_code_r  <= wr_data;
               acc_wdata_r <= cmd_wdata;
            end else if (wr_data == `DSP_CMD_SET_FULL) begin
               full_address_mode_r <= 1'b1;
            end else if (wr_data == `DSP_CMD_CLR_FULL) begin
               full_address_mode_r <= 1'b0;
            end
         end
      end
   end

   // bus grant control register; reserved bits are not stored
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_grant_enable_r <= BUS_CTL_RST[`DSP_BUS_EN_BIT];
         bus_grant_force_r  <= BUS_CTL_RST[`DSP_BUS_FORCE_BIT];
      end else if (bus_wr) begin
         bus_grant_enable_r <= wr_data[`DSP_BUS_EN_BIT];
         bus_grant_force_r  <= wr_data[`DSP_BUS_FORCE_BIT];
      end
   end

   // bus request comes from a pin in another domain
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         breq_s1_r <= 1'b0;
         breq_s2_r <= 1'b0;
      end else begin
         breq_s1_r <= bus_request_pin_i;
         breq_s2_r <= breq_s1_r;
      end
   end

   // grant: forced, or requested while enabled and no access is in flight;
   // a command accepted while granted still runs, the master owns that order
   always @* begin
      bus_ack_nxt = bus_grant_force_r;
      if (bus_grant_enable_r && breq_s2_r && !acc_req_r) begin
         bus_ack_nxt = 1'b1;
      end
   end

   // registered so the pin never glitches
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_ack_r <= 1'b0;
      end else begin
         bus_ack_r <= bus_ack_nxt;
      end
   end

   // outputs toward the cpu and the bus pin
   assign acc_req_o             = acc_req_r;
   assign acc_code_o            = acc_code_r;
   assign acc_wdata_o           = acc_wdata_r;
   assign acc_long_sp_o         = full_address_mode_r;
   assign full_address_mode_o   = full_address_mode_r;
   assign bus_acknowledge_pin_o = bus_ack_r;

endmodule // dsp_cpu_access

/* design/dsp_link.v */
// Purpose: serial slave of the debug link; turns frames into register writes and reads
// Assumes: link clock and data are asynchronous pins, sampled on clk_i
// Notes:   start = data falls while clock high, stop = data rises while clock high;
//          each byte is eight bits msb first followed by one separator bit
`timescale 1ns/1ps
`include "dsp_consts.vh"

module dsp_link (
   input  wire       clk_i,
   input  wire       nrst_i,
   input  wire       link_clk_i,
   input  wire       link_data_i,
   output wire       link_data_o,
   output wire       link_data_oe_o,
   output wire       wr_stb_o,
   output wire [6:0] wr_addr_o,
   output wire [7:0] wr_data_o,
   output wire [6:0] rd_addr_o,
   input  wire [7:0] rd_data_i
);

   localparam ST_IDLE = 2'd0;
   localparam ST_HDR  = 2'd1;
   localparam ST_DATA = 2'd2;

   reg       clk_s1_r, clk_s2_r, clk_s3_r;
   reg       dat_s1_r, dat_s2_r, dat_s3_r;
   reg [1:0] state_r;
   reg [3:0] cnt_r;
   reg [7:0] sh_r;
   reg [6:0] addr_r;
   reg       rw_r;
   reg [7:0] out_r;
   reg       oe_r;
   reg       wr_stb_r;
   reg [6:0] wr_addr_r;
   reg [7:0] wr_data_r;

   wire rise  = clk_s2_r & ~clk_s3_r;
   wire fall  = ~clk_s2_r & clk_s3_r;
   wire start = clk_s2_r & clk_s3_r & dat_s3_r & ~dat_s2_r;
   wire stop  = clk_s2_r & clk_s3_r & ~dat_s3_r & dat_s2_r;

   // three-stage synchronisers; stage one feeds only stage two
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // link clock idles high, so reset to that level to avoid a false rise
         clk_s1_r <= 1'b1;
         clk_s2_r <= 1'b1;
         clk_s3_r <= 1'b1;
         dat_s1_r <= 1'b1;
         dat_s2_r <= 1'b1;
         dat_s3_r <= 1'b1;
      end else begin
         clk_s1_r <= link_clk_i;
         clk_s2_r <= clk_s1_r;
         clk_s3_r <= clk_s2_r;
         dat_s1_r <= link_data_i;
         dat_s2_r <= dat_s1_r;
         dat_s3_r <= dat_s2_r;
      end
   end

   // frame decoder; start or stop anywhere resynchronises the slave
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r   <= ST_IDLE;
         cnt_r     <= 4'd0;
         sh_r      <= 8'h00;
         addr_r    <= 7'h00;
         rw_r      <= 1'b0;
         out_r     <= 8'h00;
         oe_r      <= 1'b0;
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 7'h00;
         wr_data_r <= 8'h00;
      end else begin
         wr_stb_r <= 1'b0;
         if (start) begin
            state_r <= ST_HDR;
            cnt_r   <= 4'd0;
            oe_r    <= 1'b0;
         end else if (stop) begin
            state_r <= ST_IDLE;
            oe_r    <= 1'b0;
         end else begin
            case (state_r)
               ST_HDR: begin
                  if (rise) begin
                     if (cnt_r == `DSP_SEP_SLOT) begin
                        state_r <= ST_DATA;
                        cnt_r   <= 4'd0;
                     end else begin
                        sh_r  <= {sh_r[6:0], dat_s2_r};
                        cnt_r <= cnt_r + 4'd1;
                        if (cnt_r == `DSP_BITS_PER_BYTE - 4'd1) begin
                           addr_r <= sh_r[6:0];
                           rw_r   <= dat_s2_r;
                        end
                     end
                  end
               end
               ST_DATA: begin
                  if (rise) begin
                     if (cnt_r == `DSP_SEP_SLOT) begin
                        cnt_r <= 4'd0;
                     end else begin
                        sh_r  <= {sh_r[6:0], dat_s2_r};
                        cnt_r <= cnt_r + 4'd1;
                        if (cnt_r == `DSP_BITS_PER_BYTE - 4'd1) begin
                           // auto-increment lets one frame fill data bytes and command
                           addr_r <= addr_r + 7'd1;
                           if (!rw_r) begin
                              wr_stb_r  <= 1'b1;
                              wr_addr_r <= addr_r;
                              wr_data_r <= {sh_r[6:0], dat_s2_r};
                           end
                        end
                     end
                  end else if (fall && rw_r) begin
                     // read bits change on falling edges so the master samples on rising
                     if (cnt_r == 4'd0) begin
                        out_r <= rd_data_i;
                        oe_r  <= 1'b1;
                     end else if (cnt_r == `DSP_SEP_SLOT) begin
                        oe_r  <= 1'b0;
                     end else begin
                        out_r <= {out_r[6:0], 1'b0};
                     end
                  end
               end
               default: begin
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   assign link_data_o    = out_r[7];
   assign link_data_oe_o = oe_r;
   assign wr_stb_o       = wr_stb_r;
   assign wr_addr_o      = wr_addr_r;
   assign wr_data_o      = wr_data_r;
   assign rd_addr_o      = addr_r;

endmodule // dsp_link
